// ### design/phy_ext_control_irq_mask.sv
// APB register bank: extended control, interrupt mask and status, interrupt pin enable
`include "phy_ext_control_params.svh"

// Behaviour
// - Override field: auto, serial only, copper only
// - Mode bits apply only at software reset
// - Mode bits read back the mode in force
// - Edge rate three-bit code, reset zero, sticky
// - Long-frame field: standard, 9 kB, 12 kB
// - Default limits assume 100 ppm reference
// - Mask bits 14-12: speed, link, duplex
// - Mask bits 11-7: negotiation, detect, symbol, failure
// - Mask bits 5-0: remaining event sources
// - Mask bits read/write, sticky, reset zero
// - Pin enable lets pin follow pending bit
// - Pin enable clear only blocks the pin
// - Events recorded regardless of pin enable
// - Sticky bits survive software reset when enabled
// - Status clears on read; aggregate shows pending
module phy_ext_control_irq_mask
    import phy_ext_control_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [14:0] event_pulse,
    output logic [1:0] media_select_override,
    output logic far_end_loopback,
    output logic [5:0] operating_mode,
    output logic [2:0] tx_edge_rate_setting,
    output logic reduced_power_mode,
    output logic [1:0] jumbo_mode,
    output logic [15:0] max_frame_bytes,
    output logic connector_loopback,
    output logic soft_reset_pulse,
    output logic irq_pending,
    output logic interrupt_request_pin_out,
    output logic interrupt_request_pin_oe
);
    acc_state_t acc_reg, acc_next;
    logic [31:0] prdata_reg, prdata_next;
    logic err_reg, err_next;
    logic sticky_en_reg, sticky_en_next;
    logic [5:0] mode_pend_reg, mode_pend_next;
    logic [5:0] mode_act_reg, mode_act_next;
    logic [1:0] override_reg, override_next;
    logic far_loop_reg, far_loop_next;
    logic [2:0] edge_reg, edge_next;
    logic red_pwr_reg, red_pwr_next;
    logic [1:0] jumbo_reg, jumbo_next;
    logic [15:0] frame_reg, frame_next;
    logic conn_loop_reg, conn_loop_next;
    logic [15:0] mask_reg, mask_next;
    logic [14:0] status_reg, status_next;
    logic swrst_reg, swrst_next;
    logic oe_reg, oe_next;
    logic [5:0] idx;
    logic hit;
    logic done;
    logic wr;
    logic swrst;
    logic pending;
    logic [14:0] evt_set;
    logic [31:0] rd_word;

    assign idx = paddr[7:2];
    assign done = psel && penable && (acc_reg == ACC_READY);
    assign wr = done && pwrite && hit;
    assign swrst = wr && (idx == `IDX_BASIC_CONTROL) && pwdata[`SOFT_RESET_BIT];
    // Only masked-in sources are latched, independent of the pin enable
    assign evt_set = event_pulse & mask_reg[14:0] & `EVT_IMPL_MASK;
    assign pending = |(status_reg & mask_reg[14:0]);

    // Stray low or upper address bits miss every register and raise pslverr
    always_comb begin
        hit = 1'b0;
        if ((paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:8] == '0)) begin
            case (idx)
                `IDX_BASIC_CONTROL, `IDX_EXT_CTRL_STATUS, `IDX_EXT_CONTROL_ONE,
                `IDX_EXT_CONTROL_TWO, `IDX_INTERRUPT_MASK, `IDX_INTERRUPT_STATUS: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (idx)
            `IDX_EXT_CTRL_STATUS: rd_word[`STICKY_EN_BIT] = sticky_en_reg;
            `IDX_EXT_CONTROL_ONE: begin
                rd_word[`MODE_MSB:`MODE_LSB] = mode_act_reg;
                rd_word[`OVERRIDE_MSB:`OVERRIDE_LSB] = override_reg;
                rd_word[`FAR_LOOP_BIT] = far_loop_reg;
            end
            `IDX_EXT_CONTROL_TWO: begin
                rd_word[`EDGE_MSB:`EDGE_LSB] = edge_reg;
                rd_word[`REDUCED_PWR_BIT] = red_pwr_reg;
                rd_word[`JUMBO_MSB:`JUMBO_LSB] = jumbo_reg;
                rd_word[`CONN_LOOP_BIT] = conn_loop_reg;
            end
            `IDX_INTERRUPT_MASK: rd_word[15:0] = mask_reg;
            `IDX_INTERRUPT_STATUS: rd_word[15:0] = {pending, status_reg};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // One wait state so that read data comes from a flip-flop
    // Costs a cycle per transfer but keeps prdata free of decode glitches
    always_comb begin
        acc_next = acc_reg;
        prdata_next = prdata_reg;
        err_next = err_reg;
        case (acc_reg)
            ACC_IDLE: begin
                if (psel && penable) begin
                    acc_next = ACC_READY;
                    prdata_next = hit ? rd_word : 32'h0000_0000;
                    err_next = !hit;
                end
            end
            ACC_READY: acc_next = ACC_IDLE;
            default: acc_next = ACC_IDLE;
        endcase
    end

    always_comb begin
        sticky_en_next = sticky_en_reg;
        mode_pend_next = mode_pend_reg;
        mode_act_next = mode_act_reg;
        override_next = override_reg;
        far_loop_next = far_loop_reg;
        edge_next = edge_reg;
        red_pwr_next = red_pwr_reg;
        jumbo_next = jumbo_reg;
        conn_loop_next = conn_loop_reg;
        mask_next = mask_reg;
        swrst_next = swrst;
        if (swrst) begin
            mode_act_next = mode_pend_reg;
            override_next = `OVERRIDE_RST;
            far_loop_next = 1'b0;
            conn_loop_next = 1'b0;
            if (!sticky_en_reg) begin
                edge_next = `EDGE_RST;
                red_pwr_next = 1'b0;
                jumbo_next = `JUMBO_RST;
                mask_next = `MASK_RST;
            end
        end else if (wr) begin
            case (idx)
                `IDX_EXT_CTRL_STATUS: sticky_en_next = pwdata[`STICKY_EN_BIT];
                `IDX_EXT_CONTROL_ONE: begin
                    // Held as pending until the next software reset
                    mode_pend_next = pwdata[`MODE_MSB:`MODE_LSB];
                    if (pwdata[`OVERRIDE_MSB:`OVERRIDE_LSB] != MEDIA_RSVD) begin
                        override_next = pwdata[`OVERRIDE_MSB:`OVERRIDE_LSB];
                    end
                    far_loop_next = pwdata[`FAR_LOOP_BIT];
                end
                `IDX_EXT_CONTROL_TWO: begin
                    edge_next = pwdata[`EDGE_MSB:`EDGE_LSB];
                    red_pwr_next = pwdata[`REDUCED_PWR_BIT];
                    if (pwdata[`JUMBO_MSB:`JUMBO_LSB] != FRAME_RSVD) begin
                        jumbo_next = pwdata[`JUMBO_MSB:`JUMBO_LSB];
                    end
                    conn_loop_next = pwdata[`CONN_LOOP_BIT];
                end
                `IDX_INTERRUPT_MASK: mask_next = pwdata[15:0];
                default: mask_next = mask_reg;
            endcase
        end
    end

    always_comb begin
        case (jumbo_next)
            FRAME_9K: frame_next = `FRAME_9K_BYTES;
            FRAME_12K: frame_next = `FRAME_12K_BYTES;
            default: frame_next = `FRAME_STD_BYTES;
        endcase
    end

    // A read clears only the bits it reported; a new event in the same cycle wins
    // Unmasked sources are dropped, so a later mask set never raises a stale request
    always_comb begin
        status_next = status_reg;
        if (done && !pwrite && hit && (idx == `IDX_INTERRUPT_STATUS)) begin
            status_next = status_reg & ~prdata_reg[14:0];
        end
        status_next = status_next | evt_set;
        oe_next = mask_next[`PIN_EN_BIT] && (|(status_next & mask_next[14:0]));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= ACC_IDLE;
            prdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
            sticky_en_reg <= `STICKY_EN_RST;
            mode_pend_reg <= `MODE_RST;
            mode_act_reg <= `MODE_RST;
            override_reg <= `OVERRIDE_RST;
            far_loop_reg <= 1'b0;
            edge_reg <= `EDGE_RST;
            red_pwr_reg <= 1'b0;
            jumbo_reg <= `JUMBO_RST;
            frame_reg <= `FRAME_STD_BYTES;
            conn_loop_reg <= 1'b0;
            mask_reg <= `MASK_RST;
            status_reg <= `STATUS_RST;
            swrst_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            prdata_reg <= prdata_next;
            err_reg <= err_next;
            sticky_en_reg <= sticky_en_next;
            mode_pend_reg <= mode_pend_next;
            mode_act_reg <= mode_act_next;
            override_reg <= override_next;
            far_loop_reg <= far_loop_next;
            edge_reg <= edge_next;
            red_pwr_reg <= red_pwr_next;
            jumbo_reg <= jumbo_next;
            frame_reg <= frame_next;
            conn_loop_reg <= conn_loop_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            swrst_reg <= swrst_next;
            oe_reg <= oe_next;
        end
    end

    assign pready = (acc_reg == ACC_READY);
    assign prdata = prdata_reg;
    assign pslverr = pready && err_reg;
    assign media_select_override = override_reg;
    assign far_end_loopback = far_loop_reg;
    assign operating_mode = mode_act_reg;
    assign tx_edge_rate_setting = edge_reg;
    assign reduced_power_mode = red_pwr_reg;
    assign jumbo_mode = jumbo_reg;
    assign max_frame_bytes = frame_reg;
    assign connector_loopback = conn_loop_reg;
    assign soft_reset_pulse = swrst_reg;
    assign irq_pending = pending;
    // Open-drain, active low: the pin is pulled low only while enabled
    assign interrupt_request_pin_out = 1'b0;
    assign interrupt_request_pin_oe = oe_reg;

    AST_OVERRIDE_NEVER_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        media_select_override != MEDIA_RSVD) else $error("override holds reserved code");
    AST_MODE_ONLY_ON_SWRST: assert property (@(posedge pclk) disable iff (!presetn)
        (operating_mode != $past(operating_mode)) |-> $past(swrst)) else $error("mode changed without reset");
    AST_MODE_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && hit && idx == `IDX_EXT_CONTROL_ONE) |-> prdata[13:8] == operating_mode)
        else $error("mode readback not in force");
    AST_EDGE_SWRST_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
        (swrst && !sticky_en_reg) |=> tx_edge_rate_setting == 3'h0) else $error("edge rate not defaulted");
    AST_FRAME_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
        (jumbo_mode == FRAME_9K) |-> max_frame_bytes == `FRAME_9K_BYTES) else $error("frame limit wrong");
    AST_STICKY_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (swrst && sticky_en_reg) |=> $stable(mask_reg) && $stable(jumbo_mode)) else $error("sticky bit lost");
    AST_PIN_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
        interrupt_request_pin_oe == (mask_reg[15] && irq_pending)) else $error("pin not following pending");
    AST_PIN_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        (!mask_next[15] && |evt_set) |=> !interrupt_request_pin_oe
        && ((status_reg & $past(evt_set)) == $past(evt_set))) else $error("pin disable affected recording");
    AST_EVENT_RECORDED: assert property (@(posedge pclk) disable iff (!presetn)
        (event_pulse[14] && mask_reg[14]) |=> status_reg[14] ##1 status_reg[14] || $past(done))
        else $error("event not recorded");
    AST_CLEAR_ON_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (done && !pwrite && hit && idx == `IDX_INTERRUPT_STATUS && event_pulse == 15'h0000)
        |=> (status_reg & $past(prdata_reg[14:0])) == 15'h0000) else $error("status not cleared on read");

    // Soft reset, field and latching guards
    AST_MASK_SWRST_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
        (swrst && !sticky_en_reg) |=> mask_reg == 16'h0000) else $error("mask not defaulted");
    AST_MODE_TAKES_PENDING: assert property (@(posedge pclk) disable iff (!presetn)
        swrst |=> operating_mode == $past(mode_pend_reg)) else $error("pending mode not applied");
    AST_SOFT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        swrst |=> soft_reset_pulse) else $error("soft reset pulse missing");
    AST_STICKY_EN_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        swrst |=> $stable(sticky_en_reg)) else $error("sticky enable changed on soft reset");
    AST_JUMBO_NEVER_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
        jumbo_mode != FRAME_RSVD) else $error("long-frame field holds reserved code");
    AST_FRAME_LIMIT_12K: assert property (@(posedge pclk) disable iff (!presetn)
        (jumbo_mode == FRAME_12K) |-> max_frame_bytes == `FRAME_12K_BYTES) else $error("frame limit wrong");
    AST_RSVD_SOURCE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        !status_reg[6]) else $error("reserved source latched");
    AST_LATCH_MASKED_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        (status_reg & ~$past(status_reg) & ~($past(event_pulse) & $past(mask_reg[14:0]))) == 15'h0000)
        else $error("unmasked event latched");
endmodule : phy_ext_control_irq_mask

// ### pkg/phy_ext_control_params.svh
// Register indices, field positions, reset values and frame limits of the extended control bank
`ifndef PHY_EXT_CONTROL_PARAMS_SVH
`define PHY_EXT_CONTROL_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDX_BASIC_CONTROL 6'h00
`define IDX_EXT_CTRL_STATUS 6'h16
`define IDX_EXT_CONTROL_ONE 6'h17
`define IDX_EXT_CONTROL_TWO 6'h18
`define IDX_INTERRUPT_MASK 6'h19
`define IDX_INTERRUPT_STATUS 6'h1A
// Field positions
`define SOFT_RESET_BIT 15
`define STICKY_EN_BIT 9
`define MODE_MSB 13
`define MODE_LSB 8
`define OVERRIDE_MSB 7
`define OVERRIDE_LSB 6
`define FAR_LOOP_BIT 3
`define EDGE_MSB 15
`define EDGE_LSB 13
`define REDUCED_PWR_BIT 12
`define JUMBO_MSB 5
`define JUMBO_LSB 4
`define CONN_LOOP_BIT 0
`define PIN_EN_BIT 15
// Implemented event sources; bit 6 is reserved
`define EVT_IMPL_MASK 15'h7FBF
// Reset values
`define STICKY_EN_RST 1'h1
`define MODE_RST 6'h00
`define OVERRIDE_RST 2'h0
`define EDGE_RST 3'h0
`define JUMBO_RST 2'h0
`define MASK_RST 16'h0000
`define STATUS_RST 15'h0000
// Frame limits in bytes, sized for a reference clock within this ppm of the controller
`define REF_CLOCK_PPM 100
`define FRAME_STD_BYTES 16'h0600
`define FRAME_9K_BYTES 16'h2400
`define FRAME_12K_BYTES 16'h3000
`endif

// ### pkg/phy_ext_control_pkg.sv
// Types shared by the extended control register bank
package phy_ext_control_pkg;
    typedef enum logic [1:0] {MEDIA_AUTO = 2'h0, MEDIA_SERIAL = 2'h1, MEDIA_COPPER = 2'h2,
                              MEDIA_RSVD = 2'h3} media_override_t;
    typedef enum logic [1:0] {FRAME_STD = 2'h0, FRAME_9K = 2'h1, FRAME_12K = 2'h2,
                              FRAME_RSVD = 2'h3} jumbo_mode_t;
    // Edge rate codes, slowest first
    typedef enum logic [2:0] {EDGE_P5 = 3'h3, EDGE_P4 = 3'h2, EDGE_P3 = 3'h1, EDGE_P2 = 3'h0,
                              EDGE_P1 = 3'h7, EDGE_NOM = 3'h6, EDGE_M1 = 3'h5, EDGE_M2 = 3'h4} edge_rate_t;
    typedef enum logic [1:0] {ACC_IDLE = 2'b01, ACC_READY = 2'b10} acc_state_t;
endpackage : phy_ext_control_pkg

// ### dv/event_source_model.sv
// Same-clock event source and pulled-up interrupt line seen by the register bank
module event_source_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [14:0] fire,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic [14:0] event_pulse,
    output logic irq_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up holds the line high whenever the bank lets go of it
    assign irq_line = pin_oe ? pin_out : 1'b1;
    // Events leave a flop so they never change on the sampling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_pulse <= 15'h0;
        end else begin
            event_pulse <= fire;
        end
    end
endmodule : event_source_model

// ### dv/tb.sv
// Self-checking bench for the extended control and interrupt mask register bank
`include "phy_ext_control_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [14:0] event_pulse, fire;
    logic [1:0] media_select_override, jumbo_mode;
    logic far_end_loopback, reduced_power_mode, connector_loopback, soft_reset_pulse;
    logic irq_pending, pin_out, pin_oe, irq_line;
    logic [5:0] operating_mode;
    logic [2:0] tx_edge_rate_setting;
    logic [15:0] max_frame_bytes;
    logic [15:0] frame_tab [3] = '{`FRAME_STD_BYTES, `FRAME_9K_BYTES, `FRAME_12K_BYTES};
    int fails, tests_run, cycles, i, k;

    phy_ext_control_irq_mask #(.ADDR_W(12)) u_phy_ext_control_irq_mask (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_pulse(event_pulse), .media_select_override(media_select_override),
        .far_end_loopback(far_end_loopback), .operating_mode(operating_mode),
        .tx_edge_rate_setting(tx_edge_rate_setting), .reduced_power_mode(reduced_power_mode),
        .jumbo_mode(jumbo_mode), .max_frame_bytes(max_frame_bytes),
        .connector_loopback(connector_loopback), .soft_reset_pulse(soft_reset_pulse),
        .irq_pending(irq_pending), .interrupt_request_pin_out(pin_out),
        .interrupt_request_pin_oe(pin_oe));
    event_source_model u_event_source_model (.pclk(pclk), .presetn(presetn), .fire(fire),
        .pin_out(pin_out), .pin_oe(pin_oe), .event_pulse(event_pulse), .irq_line(irq_line));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {4'h0, idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [15:0] wd);
        apb(1'b1, idx, wd);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk(r, {16'h0000, exp});
    endtask : rd

    // Event reaches the bank one edge after fire is raised and is latched on the next edge
    task automatic pulse(input logic [14:0] bits);
        @(posedge pclk);
        fire <= bits;
        @(posedge pclk);
        fire <= 15'h0;
        @(posedge pclk);
        #1;
    endtask : pulse

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, fire} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IDX_EXT_CONTROL_TWO, 16'h0000);
        rd(`IDX_INTERRUPT_MASK, 16'h0000);
        rd(`IDX_EXT_CTRL_STATUS, 16'h0200);
        chk(32'(max_frame_bytes), 32'h0000_0600);
        apb(1'b0, 6'h1F, 16'h0000);
        chk({e, r[30:0]}, 32'h8000_0000);
        $display("test reset and decode done");
        for (i = 0; i < 4; i++) begin
            wr(`IDX_EXT_CONTROL_ONE, 16'(i << 6));
            k = (i == 3) ? 2 : i;
            rd(`IDX_EXT_CONTROL_ONE, 16'(k << 6));
            chk(32'(media_select_override), 32'(k));
        end
        $display("test override done");
        wr(`IDX_EXT_CONTROL_ONE, 16'h2A88);
        rd(`IDX_EXT_CONTROL_ONE, 16'h0088);
        chk({far_end_loopback, 25'h0, operating_mode}, 32'h8000_0000);
        wr(`IDX_BASIC_CONTROL, 16'h8000);
        #1;
        chk({soft_reset_pulse, 29'h0, media_select_override}, 32'h8000_0000);
        chk(32'(operating_mode), 32'h0000_002A);
        rd(`IDX_EXT_CONTROL_ONE, 16'h2A00);
        $display("test mode change done");
        for (i = 0; i < 8; i++) begin
            wr(`IDX_EXT_CONTROL_TWO, 16'(i << 13));
            rd(`IDX_EXT_CONTROL_TWO, 16'(i << 13));
            chk(32'(tx_edge_rate_setting), 32'(i));
        end
        // Limits checked only at the default clock tolerance; tighter offsets are the host's concern
        for (i = 0; i < 4; i++) begin
            wr(`IDX_EXT_CONTROL_TWO, 16'(i << 4));
            k = (i == 3) ? 2 : i;
            rd(`IDX_EXT_CONTROL_TWO, 16'(k << 4));
            chk({14'h0, jumbo_mode, max_frame_bytes}, {14'h0, 2'(k), frame_tab[k]});
        end
        $display("test edge rate and frame done");
        wr(`IDX_EXT_CONTROL_TWO, 16'hB011);
        #1;
        chk({25'h0, tx_edge_rate_setting, jumbo_mode, reduced_power_mode, connector_loopback}, 32'h0000_0057);
        wr(`IDX_INTERRUPT_MASK, 16'hFFFF);
        rd(`IDX_INTERRUPT_MASK, 16'hFFFF);
        wr(`IDX_BASIC_CONTROL, 16'h8000);
        rd(`IDX_EXT_CONTROL_TWO, 16'hB010);
        chk({25'h0, tx_edge_rate_setting, jumbo_mode, reduced_power_mode, connector_loopback}, 32'h0000_0056);
        rd(`IDX_INTERRUPT_MASK, 16'hFFFF);
        wr(`IDX_EXT_CTRL_STATUS, 16'h0000);
        wr(`IDX_BASIC_CONTROL, 16'h8000);
        rd(`IDX_EXT_CONTROL_TWO, 16'h0000);
        rd(`IDX_INTERRUPT_MASK, 16'h0000);
        rd(`IDX_EXT_CTRL_STATUS, 16'h0000);
        $display("test sticky done");
        for (i = 0; i < 15; i++) begin
            if (i != 6) begin
                rd(`IDX_INTERRUPT_STATUS, 16'h0000);
                wr(`IDX_INTERRUPT_MASK, 16'h8000 | 16'(1 << i));
                pulse(15'(1 << i));
                chk({irq_pending, 30'h0, irq_line}, 32'h8000_0000);
                rd(`IDX_INTERRUPT_STATUS, 16'h8000 | 16'(1 << i));
                #1;
                chk({irq_pending, 30'h0, irq_line}, 32'h0000_0001);
            end
        end
        wr(`IDX_INTERRUPT_MASK, 16'h0041);
        pulse(15'h0061);
        chk({irq_pending, 30'h0, pin_oe}, 32'h8000_0000);
        rd(`IDX_INTERRUPT_STATUS, 16'h8001);
        rd(`IDX_INTERRUPT_STATUS, 16'h0000);
        $display("test interrupts done");
        wrap_up();
    end
endmodule : tb
